// file: rtl/ycc_link_if.sv
`timescale 1ns/1ns
interface ycc_link_if;
	logic [15:0] pixBus;     // pixel_in_bus, upper byte = lines 8..15
	logic        pixelClock; // pixel-rate clock from the device
	logic [2:0]  timDev;     // device drive of hsync, vsync, blank
	logic [2:0]  timDevOeN;  // low while the device drives
	logic [2:0]  timSrc;     // source drive of the same pins
	logic [2:0]  timSrcOeN;  // low while the source drives
	logic [2:0]  timLine;    // resolved level, pulled high when idle
	logic        field;      // field flag, always from the device

	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	assign timLine = (~timDevOeN & timDev) | (~timSrcOeN & timSrc) | (timDevOeN & timSrcOeN);

	modport device (input pixBus, timLine, output pixelClock, timDev, timDevOeN, field);
	modport source (output pixBus, timSrc, timSrcOeN, input pixelClock, timLine, field);
endinterface

// file: rtl/ycc_pixel_formatter.sv
// Function
// R1 - input format register picks pin meaning
// R2 - 16-bit: luma upper, chroma lower
// R3 - 8-bit: muxed on upper, lower ignored
// R4 - embedded codes stripped from pixel words
// R5 - chroma alternates, blue-difference first
// R6 - samples are unsigned eight-bit codes
// R7 - luma below 16 raised to 16
// R8 - luma above 235 passed unchanged
// R9 - chroma 128 is zero, no clamp
// R10 - composite saturates, luma and chroma not
// R11 - 4:2:2 to 4:4:4, then 2x interpolation
// R12 - everything runs on one double-rate clock
// R13 - optional luma filter, chroma always filtered
// R14 - chroma quadrature modulated, summed with luma
// R15 - vbi data replaces luma when enabled
// R16 - timing master or slave to source
// R17 - polarities and active counts are programmable
// R18 - 8-bit order Cb Y Cr Y
// R19 - 16-bit capture while pixel clock low
// R20 - embedded mode ignores sync pins
// R21 - status word flags decoded, protection ignored
`timescale 1ns/1ns
module ycc_pixel_formatter
	import ycc_pkg::*;
#(
	parameter int          LINE_TOTAL_P  = LINE_TOTAL,
	parameter int          FRAME_LINES_P = FRAME_LINES,
	parameter int          HS_WIDTH_P    = HS_WIDTH,
	parameter int          VS_LINES_P    = VS_LINES,
	parameter logic [31:0] SC_INC        = SC_STEP
)
(
	input  wire logic              mclk,     // double_rate_clock
	input  wire logic              resetn,
	ycc_link_if.device             link,
	input  wire logic [4:0]        regAddr,
	input  wire logic [15:0]       regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [15:0]       regRdata,
	output logic      [7:0]        yOut,     // luma, low end clamped to 16, top unclipped
	output logic signed [8:0]      cOut,     // modulated chroma, unclipped
	output logic      [7:0]        compOut   // composite, saturated
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] avg2(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[8:1];
	endfunction

	function automatic logic [7:0] f121(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		logic [9:0] s;
		s = {2'b00, a} + {1'b0, b, 1'b0} + {2'b00, c};
		return s[9:2];
	endfunction

	function automatic logic [7:0] f14641(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] d, input logic [7:0] e);
		logic [11:0] s;
		s = {4'h0, a} + {2'b00, b, 2'b00} + {2'b00, c, 2'b00} + {3'b000, c, 1'b0}
			+ {2'b00, d, 2'b00} + {4'h0, e};
		return s[11:4];
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0]  ctrl_q, ctrl_d;       // control bits
	logic [10:0] actPix_q, actPix_d;   // active pixels per line
	logic [9:0]  actLin_q, actLin_d;   // active lines
	logic [7:0]  vbi_q, vbi_d;         // vbi luma code
	logic [15:0] rdata_q, rdata_d;     // read data, one cycle after strobe
	fmt_t        fmt;                  // selected format
	logic [2:0]  pol;                  // timing polarities
	logic        master;
	logic [10:0] pixCnt_q, pixCnt_d;   // pixel within line
	logic [9:0]  lineCnt_q, lineCnt_d; // line within frame
	logic        field_q, field_d;
	logic        vblank;
	logic        actCap;               // capture window open

	assign fmt    = fmt_t'(ctrl_q[CTRL_FMT_LSB +: 2]);   // [R1]
	assign pol    = ctrl_q[CTRL_POL_LSB +: 3];
	assign master = ctrl_q[CTRL_MST_BIT];

	// decode writes and reads; unmapped reads give zero
	always_comb
	begin
		ctrl_d   = ctrl_q;
		actPix_d = actPix_q;
		actLin_d = actLin_q;
		vbi_d    = vbi_q;
		rdata_d  = 16'h0000;
		if (regWr)
		begin
			case (regAddr)
				REG_CTRL:   ctrl_d   = regWdata[7:0];   // [R17]
				REG_ACTPIX: actPix_d = regWdata[10:0];  // [R17]
				REG_ACTLIN: actLin_d = regWdata[9:0];   // [R17]
				REG_VBI:    vbi_d    = regWdata[7:0];
				default:    ;                           // writes ignored
			endcase
		end
		if (regRd)
		begin
			case (regAddr)
				REG_CTRL:   rdata_d = {8'h00, ctrl_q};
				REG_ACTPIX: rdata_d = {5'h00, actPix_q};
				REG_ACTLIN: rdata_d = {6'h00, actLin_q};
				REG_VBI:    rdata_d = {8'h00, vbi_q};
				REG_STAT:   rdata_d = {field_q, vblank, actCap, 3'h0, lineCnt_q};
				default:    rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q   <= CTRL_RST;
			actPix_q <= ACTPIX_RST;
			actLin_q <= ACTLIN_RST;
			vbi_q    <= VBI_RST;
			rdata_q  <= 16'h0000;
		end
		else
		begin
			ctrl_q   <= ctrl_d;
			actPix_q <= actPix_d;
			actLin_q <= actLin_d;
			vbi_q    <= vbi_d;
			rdata_q  <= rdata_d;
		end
	end
	assign regRdata = rdata_q;

	// ----------------------------------------
	// video timing
	// ----------------------------------------
	logic       clkPh_q, clkPh_d;       // pixel clock phase, one pixel per two edges
	logic [2:0] tim_q, tim_d;           // asserted master outputs
	logic [2:0] inPrev_q, inPrev_d;     // previous asserted inputs
	logic       actDel_q, actDel_d;     // master active (blank inverted), one cycle late
	logic [2:0] inAss;                  // inputs with polarity removed
	logic       act656_q, vbl656_q, fld656_q, eav_q;

	assign inAss = ~(link.timLine ^ pol);                   // [R17]
	assign vblank = (fmt == FMT_656) ? vbl656_q : (lineCnt_q >= actLin_q);

	// counters follow codes, own count or source edges
	always_comb
	begin
		pixCnt_d  = pixCnt_q;
		lineCnt_d = lineCnt_q;
		field_d   = field_q;
		clkPh_d   = ~clkPh_q;                               // [R12]
		inPrev_d  = inAss;
		actDel_d  = ~tim_q[TIM_BL];
		if (fmt == FMT_656)
		begin
			// pins not looked at in this mode
			if (eav_q)
			begin
				pixCnt_d  = 11'h000;
				lineCnt_d = lineCnt_q + 10'h001;                // [R20]
			end
			else if (clkPh_q)
				pixCnt_d = pixCnt_q + 11'h001;
			if (fld656_q != field_q)
			begin
				field_d   = fld656_q;
				lineCnt_d = 10'h000;
			end
		end
		else if (master)
		begin
			if (clkPh_q)
			begin
				if (pixCnt_q == 11'(LINE_TOTAL_P - 1))
				begin
					pixCnt_d = 11'h000;
					if (lineCnt_q == 10'(FRAME_LINES_P - 1))
					begin
						lineCnt_d = 10'h000;
						field_d   = ~field_q;                   // [R16]
					end
					else
						lineCnt_d = lineCnt_q + 10'h001;
				end
				else
					pixCnt_d = pixCnt_q + 11'h001;
			end
		end
		else
		begin
			// slave: leading edges of the source syncs
			if (inAss[TIM_VS] && !inPrev_q[TIM_VS])
			begin
				lineCnt_d = 10'h000;
				field_d   = ~field_q;                         // [R16]
			end
			else if (inAss[TIM_HS] && !inPrev_q[TIM_HS])
				lineCnt_d = lineCnt_q + 10'h001;
			if (inAss[TIM_HS] && !inPrev_q[TIM_HS])
				pixCnt_d = 11'h000;
			else if (clkPh_q)
				pixCnt_d = pixCnt_q + 11'h001;
		end
		tim_d[TIM_HS] = pixCnt_q >= 11'(LINE_TOTAL_P - HS_WIDTH_P);
		tim_d[TIM_VS] = lineCnt_q >= 10'(FRAME_LINES_P - VS_LINES_P);
		tim_d[TIM_BL] = (pixCnt_q >= actPix_q) || (lineCnt_q >= actLin_q);
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pixCnt_q  <= 11'h000;
			lineCnt_q <= 10'h000;
			field_q   <= 1'b0;
			clkPh_q   <= 1'b0;
			tim_q     <= 3'h4;
			inPrev_q  <= 3'h0;
			actDel_q  <= 1'b0;
		end
		else
		begin
			pixCnt_q  <= pixCnt_d;
			lineCnt_q <= lineCnt_d;
			field_q   <= field_d;
			clkPh_q   <= clkPh_d;
			tim_q     <= tim_d;
			inPrev_q  <= inPrev_d;
			actDel_q  <= actDel_d;
		end
	end

	// master blank is seen by the source one edge late, so capture lags it
	always_comb
	begin
		case (fmt)
			FMT_656: actCap = act656_q;                         // [R20]
			default: actCap = master ? actDel_q : ~inAss[TIM_BL]; // [R16]
		endcase
	end

	assign link.timDev     = ~(tim_q ^ pol);                 // [R17]
	assign link.timDevOeN  = master ? 3'b000 : 3'b111;       // [R16]
	assign link.pixelClock = clkPh_q;
	assign link.field      = field_q;

	// ----------------------------------------
	// capture and demultiplex
	// ----------------------------------------
	logic [1:0]  wph_q, wph_d;          // word phase, 0 = Cb
	logic [23:0] hist_q, hist_d;        // last three words
	logic [7:0]  cb_q, cb_d, cr_q, cr_d, yRaw_q, yRaw_d;
	logic        pv_q, pv_d;            // new pixel this cycle
	logic        act656_d, vbl656_d, fld656_d, eav_d;
	logic [7:0]  word, lo;
	logic        capEn, isRef, skipWord;

	assign word     = link.pixBus[15:8];
	assign lo       = link.pixBus[7:0];
	assign capEn    = (fmt == FMT_16) ? ~clkPh_q : 1'b1;      // [R19]
	assign isRef    = (fmt == FMT_656) && (hist_q == {PRE_ONE, PRE_ZERO, PRE_ZERO})
		&& word[ST_MARK];                                    // [R21]
	assign skipWord = (fmt == FMT_656) && (word == PRE_ONE || word == PRE_ZERO); // [R4]

	always_comb
	begin
		wph_d    = wph_q;
		hist_d   = hist_q;
		cb_d     = cb_q;
		cr_d     = cr_q;
		yRaw_d   = yRaw_q;
		pv_d     = 1'b0;
		act656_d = act656_q;
		vbl656_d = vbl656_q;
		fld656_d = fld656_q;
		eav_d    = 1'b0;
		if (capEn)
		begin
			hist_d = {hist_q[15:0], word};
			if (isRef)
			begin
				// protection bits 3..0 left unread
				fld656_d = word[ST_F];                          // [R21]
				vbl656_d = word[ST_V];                          // [R21]
				act656_d = ~word[ST_H];                         // [R21]
				eav_d    = word[ST_H];
				wph_d    = 2'h0;
			end
			else if (!actCap)
				wph_d = 2'h0;                                   // next active word is Cb
			else if (!skipWord)
			begin
				if (fmt == FMT_16)
				begin
					yRaw_d = word;                                // [R2]
					if (!wph_q[0])
						cb_d = lo;                                  // [R5]
					else
						cr_d = lo;
					wph_d = {1'b0, ~wph_q[0]};
					pv_d  = 1'b1;
				end
				else
				begin
					// lower lines unused in the byte-wide modes
					case (wph_q)                                  // [R3]
						2'h0: cb_d = word;                          // [R18]
						2'h2: cr_d = word;                          // [R5]
						default:
						begin
							yRaw_d = word;
							pv_d   = 1'b1;
						end
					endcase
					wph_d = wph_q + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			wph_q    <= 2'h0;
			hist_q   <= 24'h000000;
			cb_q     <= CHROMA_ZERO;
			cr_q     <= CHROMA_ZERO;
			yRaw_q   <= LUMA_BLACK;
			pv_q     <= 1'b0;
			act656_q <= 1'b0;
			vbl656_q <= 1'b1;
			fld656_q <= 1'b0;
			eav_q    <= 1'b0;
		end
		else
		begin
			wph_q    <= wph_d;
			hist_q   <= hist_d;
			cb_q     <= cb_d;
			cr_q     <= cr_d;
			yRaw_q   <= yRaw_d;
			pv_q     <= pv_d;
			act656_q <= act656_d;
			vbl656_q <= vbl656_d;
			fld656_q <= fld656_d;
			eav_q    <= eav_d;
		end
	end

	// ----------------------------------------
	// chroma: hold, interpolate, filter
	// ----------------------------------------
	logic [7:0] chIn [2];               // 4:4:4 chroma held per pixel
	logic [7:0] chF  [2];               // filtered chroma
	assign chIn[0] = cb_q;
	assign chIn[1] = cr_q;

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chroma
		logic [7:0]  cur_q, cur_d;          // last pixel sample
		logic [31:0] tap_q, tap_d;          // four older double-rate samples
		logic [7:0]  smp;
		// midpoint on the pixel cycle, hold between
		always_comb
		begin
			smp   = pv_q ? avg2(cur_q, chIn[ch]) : cur_q;       // [R11]
			cur_d = pv_q ? chIn[ch] : cur_q;
			tap_d = {tap_q[23:0], smp};
		end
		always_ff @(posedge mclk or negedge resetn)
		begin
			if (!resetn)
			begin
				cur_q <= CHROMA_ZERO;
				tap_q <= {4{CHROMA_ZERO}};
			end
			else
			begin
				cur_q <= cur_d;
				tap_q <= tap_d;
			end
		end
		// narrow five-tap smoother, never bypassed
		assign chF[ch] = f14641(smp, tap_q[7:0], tap_q[15:8], tap_q[23:16],
			tap_q[31:24]);                                     // [R13]
	end

	// ----------------------------------------
	// luma, modulation, composite
	// ----------------------------------------
	logic [7:0]        yCur_q, yCur_d;      // last clamped luma
	logic [15:0]       yTap_q, yTap_d;      // two older samples
	logic [31:0]       scPh_q, scPh_d;      // subcarrier phase
	logic [7:0]        yOut_d, compOut_d;
	logic signed [8:0] cOut_d;
	logic [7:0]        yCl, yS, yF;
	logic signed [8:0] u, v;
	logic signed [9:0] sum;

	// unsigned codes; only the low end is clamped
	assign yCl = (yRaw_q < LUMA_BLACK) ? LUMA_BLACK : yRaw_q;  // [R6] [R7] [R8]
	// 128 offset removed, no range limit on chroma
	assign u = $signed({1'b0, chF[0]}) - $signed({1'b0, CHROMA_ZERO}); // [R9]
	assign v = $signed({1'b0, chF[1]}) - $signed({1'b0, CHROMA_ZERO}); // [R9]

	always_comb
	begin
		yS     = pv_q ? avg2(yCur_q, yCl) : yCur_q;           // [R11]
		yCur_d = pv_q ? yCl : yCur_q;
		yTap_d = {yTap_q[7:0], yS};
		yF     = ctrl_q[CTRL_LPF_BIT] ? f121(yS, yTap_q[7:0], yTap_q[15:8])
			: yTap_q[7:0];                                     // [R13]
		yOut_d = (ctrl_q[CTRL_VBI_BIT] && vblank) ? vbi_q : yF; // [R15]
		scPh_d = scPh_q + SC_INC;
		// four-phase carrier: +u, +v, -u, -v
		case (scPh_q[31:30])                                   // [R14]
			2'h0:    cOut_d = u;
			2'h1:    cOut_d = v;
			2'h2:    cOut_d = -u;
			default: cOut_d = -v;
		endcase
		sum = $signed({2'b00, yOut_d}) + {cOut_d[8], cOut_d}; // [R14]
		// only the sum is limited; separate outputs may exceed range
		if (sum < 0)
			compOut_d = 8'h00;                                  // [R10]
		else if (sum > $signed({2'b00, COMP_MAX}))
			compOut_d = COMP_MAX;                               // [R10]
		else
			compOut_d = sum[7:0];
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			yCur_q  <= LUMA_BLACK;
			yTap_q  <= {2{LUMA_BLACK}};
			scPh_q  <= 32'h0000_0000;
			yOut    <= LUMA_BLACK;
			cOut    <= 9'sh000;
			compOut <= LUMA_BLACK;
		end
		else
		begin
			yCur_q  <= yCur_d;
			yTap_q  <= yTap_d;
			scPh_q  <= scPh_d;
			yOut    <= yOut_d;
			cOut    <= cOut_d;
			compOut <= compOut_d;
		end
	end
endmodule

// file: rtl/ycc_pkg.sv
package ycc_pkg;
	// ----------------------------------------
	// input formats
	// ----------------------------------------
	typedef enum logic [1:0] {FMT_16, FMT_8, FMT_656, FMT_RSV} fmt_t;

	// ----------------------------------------
	// register map, byte offsets
	// ----------------------------------------
	localparam logic [4:0]  REG_CTRL   = 5'h00; // format, filter, vbi, master, polarity
	localparam logic [4:0]  REG_ACTPIX = 5'h04; // active pixels per line
	localparam logic [4:0]  REG_ACTLIN = 5'h08; // active lines per field
	localparam logic [4:0]  REG_VBI    = 5'h0c; // luma code inserted in vbi lines
	localparam logic [4:0]  REG_STAT   = 5'h10; // field, vblank, active, line count

	// control fields
	localparam int          CTRL_FMT_LSB = 0;   // two bits
	localparam int          CTRL_LPF_BIT = 2;   // luma low-pass enable
	localparam int          CTRL_VBI_BIT = 3;   // vbi insertion enable
	localparam int          CTRL_MST_BIT = 4;   // 1 = timing master
	localparam int          CTRL_POL_LSB = 5;   // three bits, 1 = active high

	// reset values
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [10:0] ACTPIX_RST = 11'h2d0;
	localparam logic [9:0]  ACTLIN_RST = 10'h1e0;
	localparam logic [7:0]  VBI_RST    = 8'h00;

	// ----------------------------------------
	// timing pins and codes
	// ----------------------------------------
	localparam int          TIM_HS = 0;         // horizontal sync
	localparam int          TIM_VS = 1;         // vertical sync
	localparam int          TIM_BL = 2;         // blank
	localparam logic [7:0]  LUMA_BLACK  = 8'h10;
	localparam logic [7:0]  CHROMA_ZERO = 8'h80;
	localparam logic [7:0]  COMP_MAX    = 8'hff;
	localparam logic [7:0]  PRE_ONE     = 8'hff;
	localparam logic [7:0]  PRE_ZERO    = 8'h00;
	localparam int          ST_MARK = 7;
	localparam int          ST_F    = 6;
	localparam int          ST_V    = 5;
	localparam int          ST_H    = 4;

	// line and frame counts, in pixels and lines
	localparam int          LINE_TOTAL  = 858;
	localparam int          FRAME_LINES = 525;
	localparam int          HS_WIDTH    = 64;
	localparam int          VS_LINES    = 3;
	localparam logic [31:0] SC_STEP     = 32'h2000_0000;
endpackage

// file: rtl/ycc_video_source.sv
`timescale 1ns/1ns
module ycc_video_source
	import ycc_pkg::*;
#(
	parameter int LINE_TOTAL_P  = LINE_TOTAL,
	parameter int FRAME_LINES_P = FRAME_LINES,
	parameter int HS_WIDTH_P    = HS_WIDTH,
	parameter int VS_LINES_P    = VS_LINES
)
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	ycc_link_if.source       link,
	input  wire fmt_t        fmt,        // format, same as the device's
	input  wire logic        driveSync,  // source makes the timing
	input  wire logic [2:0]  pol,        // 1 = active high, per pin
	input  wire logic [10:0] actPix,     // active pixels per line
	input  wire logic [9:0]  actLin,     // active lines
	input  wire logic [7:0]  yIn,        // luma to send
	input  wire logic [7:0]  cbIn,       // blue difference to send
	input  wire logic [7:0]  crIn,       // red difference to send
	output logic             pixReq      // yIn taken at this edge
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [11:0] step_q, step_d;         // word or pixel within line
	logic [9:0]  line_q, line_d;
	logic        fld_q, fld_d;
	logic [1:0]  k_q, k_d;               // word index in active run
	logic [15:0] pix_q, pix_d;           // pin drive
	logic [2:0]  tim_q, tim_d;           // asserted sync outputs
	logic        is16, is656, ownAct, act, adv, vbl;
	logic [11:0] perLine, actSteps, hsFrom, eIdx, sIdx;

	assign is16     = (fmt == FMT_16);
	assign is656    = (fmt == FMT_656);
	assign perLine  = is16 ? 12'(LINE_TOTAL_P) : 12'(2 * LINE_TOTAL_P);
	assign actSteps = is16 ? {1'b0, actPix} : {actPix, 1'b0};
	assign hsFrom   = is16 ? 12'(LINE_TOTAL_P - HS_WIDTH_P)
		: 12'(2 * (LINE_TOTAL_P - HS_WIDTH_P));
	assign ownAct   = (step_q < actSteps) && (line_q < actLin);
	assign vbl      = line_q >= actLin;
	// embedded mode or source-driven sync use own timing; else follow device blank
	assign act      = (is656 || driveSync) ? ownAct
		: (link.timLine[TIM_BL] ^ pol[TIM_BL]);              // [R16]
	// wide mode: device takes data while pixel clock is low
	assign adv      = is16 ? ~link.pixelClock : 1'b1;       // [R19]
	assign eIdx     = step_q - actSteps;
	assign sIdx     = step_q - (perLine - 12'h004);

	function automatic logic [7:0] noCode(input logic [7:0] w);
		return (w == PRE_ONE) ? 8'hfe : (w == PRE_ZERO) ? 8'h01 : w;
	endfunction

	// ----------------------------------------
	// stream generator
	// ----------------------------------------
	always_comb
	begin
		step_d = step_q;
		line_d = line_q;
		fld_d  = fld_q;
		k_d    = k_q;
		pix_d  = pix_q;
		tim_d  = tim_q;
		pixReq = 1'b0;
		if (adv)
		begin
			if (step_q >= perLine - 12'h001)
			begin
				step_d = 12'h000;
				if (line_q == 10'(FRAME_LINES_P - 1))
				begin
					line_d = 10'h000;
					fld_d  = ~fld_q;
				end
				else
					line_d = line_q + 10'h001;
			end
			else
				step_d = step_q + 12'h001;
			k_d = act ? k_q + 2'h1 : 2'h0;
			tim_d[TIM_HS] = step_q >= hsFrom;
			tim_d[TIM_VS] = line_q >= 10'(FRAME_LINES_P - VS_LINES_P);
			tim_d[TIM_BL] = ~ownAct;
			if (act && is16)
			begin
				pix_d  = {yIn, k_q[0] ? crIn : cbIn};          // [R2] [R5]
				pixReq = 1'b1;
			end
			else if (act)
			begin
				// Cb Y Cr Y on the upper lines only
				case (k_q)                                      // [R18] [R3]
					2'h0:    pix_d = {is656 ? noCode(cbIn) : cbIn, 8'h00};
					2'h2:    pix_d = {is656 ? noCode(crIn) : crIn, 8'h00};
					default: pix_d = {is656 ? noCode(yIn) : yIn, 8'h00};
				endcase
				pixReq = k_q[0];
			end
			else if (is656 && step_q >= actSteps && eIdx < 12'h004)
				pix_d = {(eIdx[1:0] == 2'h3) ? {1'b1, fld_q, vbl, 1'b1, 4'h0}
					: (eIdx[1:0] == 2'h0) ? PRE_ONE : PRE_ZERO, 8'h00}; // [R4]
			else if (is656 && step_q >= perLine - 12'h004)
				pix_d = {(sIdx[1:0] == 2'h3) ? {1'b1, fld_q, vbl, 1'b0, 4'h0}
					: (sIdx[1:0] == 2'h0) ? PRE_ONE : PRE_ZERO, 8'h00}; // [R4]
			else
				pix_d = {(is16 || step_q[0]) ? LUMA_BLACK : CHROMA_ZERO, CHROMA_ZERO};
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			step_q <= 12'h000;
			line_q <= 10'h000;
			fld_q  <= 1'b0;
			k_q    <= 2'h0;
			pix_q  <= {LUMA_BLACK, CHROMA_ZERO};
			tim_q  <= 3'h4;
		end
		else
		begin
			step_q <= step_d;
			line_q <= line_d;
			fld_q  <= fld_d;
			k_q    <= k_d;
			pix_q  <= pix_d;
			tim_q  <= tim_d;
		end
	end

	assign link.pixBus    = pix_q;
	assign link.timSrc    = ~(tim_q ^ pol);
	assign link.timSrcOeN = driveSync ? 3'b000 : 3'b111;  // [R16]
endmodule

// file: tb/test_ycbcr_pixel_input_formatter.sv
`timescale 1ns/1ns
`define CHECK(a, e) begin nCompared++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: %h not %h", $time, a, e); end end
module test_ycbcr_pixel_input_formatter;
	import ycc_pkg::*;
	logic              mclk, resetn, regWr, regRd, driveSync, pixReq, anyC, reqSeen;
	logic [10:0]       actPix;   // source active pixels, matches the register write
	logic [9:0]        actLin;   // source active lines, matches the register write
	logic [4:0]        regAddr;
	logic [15:0]       regWdata, regRdata;
	logic [7:0]        yOut, compOut, yIn, cbIn, crIn, minY, maxY, maxComp;
	logic signed [8:0] cOut;
	logic [2:0]        pol;
	fmt_t              fmt;
	int                miscompares, nCompared, cyc;
	ycc_link_if link ();
	// short line and frame keep each run to a few frames; default sync widths fit
	ycc_pixel_formatter #(.LINE_TOTAL_P(80), .FRAME_LINES_P(12)) u_ycc_pixel_formatter (
		.mclk, .resetn, .link, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .yOut,
		.cOut, .compOut);
	ycc_video_source #(.LINE_TOTAL_P(80), .FRAME_LINES_P(12)) u_ycc_video_source (.mclk,
		.resetn, .link, .fmt, .driveSync, .pol, .actPix, .actLin, .yIn, .cbIn, .crIn,
		.pixReq);
	ycc_link_chk u_ycc_link_chk (.mclk, .resetn, .pixBus(link.pixBus),
		.pixelClock(link.pixelClock), .timDev(link.timDev), .timDevOeN(link.timDevOeN),
		.timSrcOeN(link.timSrcOeN), .timLine(link.timLine), .field(link.field));
	// ----
	// clock and hang guard
	// ----
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			summarize();
		end
	end
	// ----
	// register port and measurement tasks
	// ----
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge mclk);
		regWr    <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd   <= 1'b0;
		@(negedge mclk); // data stands only in this cycle
		`CHECK(regRdata, e)
	endtask
	// both ends set alike, settle, then track extremes over a frame
	task run(input logic [7:0] ctrl, y, cb, cr, mn, mx, mc);
		wr(REG_CTRL, {8'h00, ctrl});
		fmt       <= fmt_t'(ctrl[1:0]);
		driveSync <= !ctrl[4];
		pol       <= ctrl[7:5];
		yIn       <= y;
		cbIn      <= cb;
		crIn      <= cr;
		// a full frame of settling flushes luma held over from the last run
		repeat (2000) @(posedge mclk);
		{minY, maxY, maxComp, anyC, reqSeen} = {8'hff, 8'h00, 8'h00, 2'b00};
		repeat (2000)
		begin
			@(negedge mclk);
			minY = (yOut < minY) ? yOut : minY;
			maxY = (yOut > maxY) ? yOut : maxY;
			maxComp = (compOut > maxComp) ? compOut : maxComp;
			anyC = anyC | (cOut != 9'sh000);
			// pixReq marks the edge that loads the word; it stands a cycle later
			if (reqSeen)
				`CHECK(link.pixBus[15:8], y)
			reqSeen = pixReq;
		end
		if (mn != 8'h00)
			`CHECK(minY, mn)
		`CHECK(maxY, mx)
		`CHECK(maxComp, mc)
		`CHECK(anyC, cb != 8'h80)
	endtask
	task summarize();
		$display("compared %0d, mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		{regAddr, regWdata, regWr, regRd, resetn} = '0;
		fmt = FMT_16;
		{driveSync, pol, yIn, cbIn, crIn} = {1'b1, 3'h0, 24'h108080};
		{actPix, actLin} = {11'h010, 10'h008};
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		rd(REG_STAT, 16'h2000);
		rd(REG_CTRL, 16'h0000);
		rd(REG_ACTPIX, 16'h02d0);
		rd(REG_ACTLIN, 16'h01e0);
		rd(5'h14, 16'h0000);
		wr(REG_ACTPIX, 16'h0010);
		wr(REG_ACTLIN, 16'h0008);
		wr(REG_VBI, 16'h00c0);
		wr(5'h14, 16'hffff); // unmapped, must be dropped
		rd(REG_ACTPIX, 16'h0010);
		rd(REG_VBI, 16'h00c0);
		run(8'h00, 8'h05, 8'h80, 8'h80, 8'h10, 8'h10, 8'h10);
		run(8'h01, 8'hf0, 8'h80, 8'h80, 8'h00, 8'hf0, 8'hf0);
		run(8'h05, 8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 8'h80);
		run(8'h09, 8'h20, 8'h80, 8'h80, 8'h00, 8'hc0, 8'hc0);
		run(8'hf1, 8'h30, 8'h80, 8'h80, 8'h00, 8'h30, 8'h30);
		// embedded mode last: leaving it could cut a reference code short
		run(8'h02, 8'hf0, 8'hf0, 8'hf0, 8'h00, 8'hf0, 8'hff);
		summarize();
	end
endmodule

// file: tb/ycc_link_chk.sv
`timescale 1ns/1ns
// ----
// link checker, watches both ends
// ----
module ycc_link_chk (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic [15:0] pixBus,
	input wire logic        pixelClock,
	input wire logic [2:0]  timDev,
	input wire logic [2:0]  timDevOeN,
	input wire logic [2:0]  timSrcOeN,
	input wire logic [2:0]  timLine,
	input wire logic        field
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// pixel-rate clock is half of mclk
	property p_clk; 1 |=> pixelClock != $past(pixelClock); endproperty
	a_clk: assert property (p_clk) else $error("pixel clock stuck");
	// timing pins are driven as a group or not at all
	property p_doe; timDevOeN == 3'h0 || timDevOeN == 3'h7; endproperty
	a_doe: assert property (p_doe) else $error("device enables split");
	property p_soe; timSrcOeN == 3'h0 || timSrcOeN == 3'h7; endproperty
	a_soe: assert property (p_soe) else $error("source enables split");
	// direction only moves on a control write, never flickers
	property p_oe; $changed(timDevOeN) |=> $stable(timDevOeN) [*4]; endproperty
	a_oe: assert property (p_oe) else $error("enable flicker");
	property p_drv; timDevOeN == 3'h0 |-> timLine == timDev; endproperty
	a_drv: assert property (p_drv) else $error("pin not device level");
	// idle bus is black luma, zero chroma
	property p_rst; $rose(resetn) |-> pixBus == 16'h1080 && !field && !pixelClock; endproperty
	a_rst: assert property (p_rst) else $error("bad idle after reset");
	// reference code: one all-ones word, two all-zero words, then status
	property p_pre; pixBus[15:8] == 8'hff |=> pixBus[15:8] == 8'h00 [*2]; endproperty
	a_pre: assert property (p_pre) else $error("broken preamble");
	property p_st; pixBus[15:8] == 8'hff ##1 pixBus[15:8] == 8'h00 [*2] |=> pixBus[15]; endproperty
	a_st: assert property (p_st) else $error("status mark low");
endmodule
